// file: src/dsi_read_response_framer.sv
`timescale 1ns/1ns
`include "resp_framer_defs.svh"

// Behaviour
// - command one-byte reply uses type 21h
// - one-byte reply: second payload byte zero
// - command two-byte reply uses type 22h
// - generic long reply uses type 1Ah
// - generic one-byte reply uses type 11h
// - generic two-byte reply uses type 12h
// - identifier: channel zero, type below
// - long: header, count, ECC, payload, CRC
// - reply family follows request family
// - low-power actions plus high-speed, no tearing
// - device sends only reports and replies
// - clock lane handled automatically
// - error report type 02h, drop bad
// - after turnaround: reply, ack or report
module dsi_read_response_framer
    import resp_framer_pkg::*;
#(
    parameter int MAX_LEN = 16
) (
    // Clock and reset
    input  wire logic                       clk_in,
    input  wire logic                       reset_in,
    // Reply request from command logic
    input  wire logic                       reply_start_in,
    input  wire logic                       reply_generic_in,
    input  wire logic [15:0]                reply_len_in,
    input  wire logic [MAX_LEN-1:0][7:0]    reply_data_in,
    // Receive status of last host packet
    input  wire logic                       turnaround_in,
    input  wire logic [15:0]                rx_errors_in,
    // Link side
    output logic                            tx_bit_out,
    output logic                            tx_strobe_out,
    output logic                            tx_active_out,
    output logic                            ack_out,
    output logic                            turn_back_out,
    output logic                            rx_discard_out
);

    initial begin
        if (MAX_LEN < 3 || MAX_LEN > 65535) begin
            $error("MAX_LEN out of range");
        end
    end

    // ==========================================
    // Functions
    function automatic logic [7:0] header_ecc(input logic [23:0] d);
        logic [7:0] p;
        p    = 8'h00;
        p[0] = ^(d & 24'hF12CB7);
        p[1] = ^(d & 24'hF2555B);
        p[2] = ^(d & 24'h749A6D);
        p[3] = ^(d & 24'hB8E38E);
        p[4] = ^(d & 24'hDF03F0);
        p[5] = ^(d & 24'hEFFC00);
        return p;
    endfunction

    function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = ((r[0] ^ b[i]) ? ({1'b0, r[15:1]} ^ `CRC_POLY_REFLECTED) : {1'b0, r[15:1]});
        end
        return r;
    endfunction

    function automatic logic [5:0] reply_type(input logic gen, input logic [15:0] len);
        logic [5:0] t;
        t = `DT_ACK_ERROR_REPORT;
        if (len == 16'h0001) begin
            t = gen ? `DT_GENERIC_SHORT_REPLY_ONE : `DT_COMMAND_SHORT_REPLY_ONE;
        end else if (len == 16'h0002) begin
            t = gen ? `DT_GENERIC_SHORT_REPLY_TWO : `DT_COMMAND_SHORT_REPLY_TWO;
        end else begin
            t = gen ? `DT_GENERIC_LONG_READ_REPLY : `DT_COMMAND_LONG_READ_REPLY;
        end
        return t;
    endfunction

    // ==========================================
    // State
    typedef struct packed {
        framer_state_e        state;
        logic [3:0][7:0]      hdr;
        logic [1:0]           idx;
        logic [15:0]          len;
        logic [15:0]          cnt;
        logic [15:0]          crc;
        logic                 crc_hi;
        logic [15:0]          errs;
        logic                 err_after;
        logic                 load;
        logic [7:0]           byte_v;
        logic                 active;
        logic                 ack;
        logic                 turn;
        logic                 discard;
        logic                 pend;
    } framer_s;

    framer_s                cur;
    framer_s                next_cur;
    logic [MAX_LEN-1:0][7:0] data_q;
    logic                   ser_busy;
    logic                   ser_bit;
    logic                   ser_strobe;
    logic [23:0]            next_hdr3;

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            data_q <= '0;
        end else if (cur.state == ST_IDLE && reply_start_in) begin
            data_q <= reply_data_in;
        end
    end

    always_comb begin
        next_cur         = cur;
        next_cur.load    = 1'b0;
        next_cur.ack     = 1'b0;
        next_cur.turn    = 1'b0;
        next_cur.discard = 1'b0;
        next_hdr3        = 24'h000000;
        case (cur.state)
            ST_IDLE: begin
                next_cur.active = 1'b0;
                if (turnaround_in) begin
                    next_cur.discard = (rx_errors_in != 16'h0000);
                    next_cur.errs    = rx_errors_in;
                    next_cur.pend    = 1'b1;
                end
                if (reply_start_in && reply_len_in != 16'h0000) begin
                    next_hdr3[7:0]   = {`VC_VALUE, reply_type(reply_generic_in, reply_len_in)};
                    if (reply_len_in > 16'h0002) begin
                        next_hdr3[23:8] = reply_len_in;
                    end else begin
                        next_hdr3[15:8]  = reply_data_in[0];
                        next_hdr3[23:16] = (reply_len_in == 16'h0001) ? `ZERO_BYTE : reply_data_in[1];
                    end
                    next_cur.hdr       = {header_ecc(next_hdr3), next_hdr3};
                    next_cur.len       = reply_len_in;
                    next_cur.idx       = 2'h0;
                    next_cur.err_after = cur.errs[`ERR_CORRECTED_BIT];
                    next_cur.pend      = 1'b0;
                    next_cur.state     = ST_HEADER;
                    next_cur.active    = 1'b1;
                end else if (cur.pend) begin
                    next_cur.pend = 1'b0;
                    if (cur.errs == 16'h0000) begin
                        next_cur.ack   = 1'b1;
                        next_cur.state = ST_ACK;
                    end else begin
                        next_hdr3       = {cur.errs, `VC_VALUE, `DT_ACK_ERROR_REPORT};
                        next_cur.hdr    = {header_ecc(next_hdr3), next_hdr3};
                        next_cur.idx    = 2'h0;
                        next_cur.len    = 16'h0000;
                        next_cur.errs   = 16'h0000;
                        next_cur.state  = ST_ERRHDR;
                        next_cur.active = 1'b1;
                    end
                end
            end
            ST_HEADER, ST_ERRHDR: begin
                if (!ser_busy && !cur.load) begin
                    next_cur.load   = 1'b1;
                    next_cur.byte_v = cur.hdr[cur.idx];
                    next_cur.idx    = cur.idx + 2'h1;
                    if (cur.idx == 2'h3) begin
                        next_cur.cnt = 16'h0000;
                        next_cur.crc = `CRC_SEED;
                        if (cur.state == ST_HEADER && cur.len > 16'h0002) begin
                            next_cur.state = ST_DATA;
                        end else if (cur.state == ST_HEADER && cur.err_after) begin
                            next_cur.err_after = 1'b0;
                            next_hdr3          = {cur.errs, `VC_VALUE, `DT_ACK_ERROR_REPORT};
                            next_cur.hdr       = {header_ecc(next_hdr3), next_hdr3};
                            next_cur.errs      = 16'h0000;
                            next_cur.state     = ST_ERRHDR;
                        end else begin
                            next_cur.errs  = 16'h0000;
                            next_cur.state = ST_TURN;
                        end
                    end
                end
            end
            ST_DATA: begin
                if (!ser_busy && !cur.load) begin
                    next_cur.load   = 1'b1;
                    next_cur.byte_v = (cur.cnt < 16'(MAX_LEN)) ? data_q[cur.cnt[$clog2(MAX_LEN)-1:0]] : 8'h00;
                    next_cur.crc    = crc_byte(cur.crc, next_cur.byte_v);
                    next_cur.cnt    = cur.cnt + 16'h0001;
                    if (cur.cnt + 16'h0001 == cur.len) begin
                        next_cur.crc_hi = 1'b0;
                        next_cur.state  = ST_CRC;
                    end
                end
            end
            ST_CRC: begin
                if (!ser_busy && !cur.load) begin
                    next_cur.load   = 1'b1;
                    next_cur.byte_v = cur.crc_hi ? cur.crc[15:8] : cur.crc[7:0];
                    next_cur.crc_hi = 1'b1;
                    if (cur.crc_hi) begin
                        if (cur.err_after) begin
                            next_cur.err_after = 1'b0;
                            next_hdr3          = {cur.errs, `VC_VALUE, `DT_ACK_ERROR_REPORT};
                            next_cur.hdr       = {header_ecc(next_hdr3), next_hdr3};
                            next_cur.idx       = 2'h0;
                            next_cur.state     = ST_ERRHDR;
                        end else begin
                            next_cur.state = ST_TURN;
                        end
                        next_cur.errs = 16'h0000;
                    end
                end
            end
            ST_ACK: begin
                next_cur.turn  = 1'b1;
                next_cur.state = ST_IDLE;
            end
            ST_TURN: begin
                if (!ser_busy && !cur.load) begin
                    next_cur.turn   = 1'b1;
                    next_cur.active = 1'b0;
                    next_cur.state  = ST_IDLE;
                end
            end
            default: begin
                next_cur.state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cur       <= '0;
            cur.state <= ST_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    byte_serializer #(
        .BIT_CYCLES (`LINK_BIT_CYCLES)
    ) u_ser (
        .clk_in         (clk_in),
        .reset_in       (reset_in),
        .load_in        (cur.load),
        .byte_in        (cur.byte_v),
        .busy_out       (ser_busy),
        .bit_out        (ser_bit),
        .bit_strobe_out (ser_strobe)
    );

    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            tx_bit_out    <= 1'b0;
            tx_strobe_out <= 1'b0;
        end else begin
            tx_bit_out    <= ser_bit;
            tx_strobe_out <= ser_strobe;
        end
    end

    assign tx_active_out  = cur.active;
    assign ack_out        = cur.ack;
    assign turn_back_out  = cur.turn;
    assign rx_discard_out = cur.discard;

endmodule

// file: src/resp_framer_defs.svh
`ifndef RESP_FRAMER_DEFS_SVH
`define RESP_FRAMER_DEFS_SVH

// Packet data types
`define DT_ACK_ERROR_REPORT        6'h02
`define DT_COMMAND_LONG_READ_REPLY 6'h1C
`define DT_COMMAND_SHORT_REPLY_ONE 6'h21
`define DT_COMMAND_SHORT_REPLY_TWO 6'h22
`define DT_GENERIC_LONG_READ_REPLY 6'h1A
`define DT_GENERIC_SHORT_REPLY_ONE 6'h11
`define DT_GENERIC_SHORT_REPLY_TWO 6'h12

// Identifier, filler byte, checksum and error-bit values
`define VC_VALUE                   2'h0
`define ZERO_BYTE                  8'h00
`define CRC_SEED                   16'hFFFF
`define CRC_POLY_REFLECTED         16'h8408
`define ERR_CHECKSUM_BIT           10
`define ERR_CORRECTED_BIT          8

// Link timing
`define LINK_BIT_NS                400
`define CLK_NS                     50
`define LINK_BIT_CYCLES            ((`LINK_BIT_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// file: src/resp_framer_pkg.sv
package resp_framer_pkg;

    typedef enum logic [2:0] {
        REPLY_NONE = 3'h0,
        REPLY_ONE  = 3'h1,
        REPLY_TWO  = 3'h2,
        REPLY_LONG = 3'h3
    } reply_size_e;

    typedef enum logic [6:0] {
        ST_IDLE   = 7'h01,
        ST_HEADER = 7'h02,
        ST_DATA   = 7'h04,
        ST_CRC    = 7'h08,
        ST_ERRHDR = 7'h10,
        ST_ACK    = 7'h20,
        ST_TURN   = 7'h40
    } framer_state_e;

endpackage

// file: src/byte_serializer.sv
`timescale 1ns/1ns
`include "resp_framer_defs.svh"

module byte_serializer
    import resp_framer_pkg::*;
#(
    parameter int BIT_CYCLES = `LINK_BIT_CYCLES
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       reset_in,
    // Byte side
    input  wire logic       load_in,
    input  wire logic [7:0] byte_in,
    output logic            busy_out,
    // Link side
    output logic            bit_out,
    output logic            bit_strobe_out
);

    initial begin
        if (BIT_CYCLES < 1 || BIT_CYCLES > 255) begin
            $error("BIT_CYCLES out of range");
        end
    end

    typedef struct packed {
        logic [7:0] shift;
        logic [3:0] left;
        logic [7:0] timer;
        logic       bit_val;
        logic       strobe;
    } ser_s;

    ser_s cur;
    ser_s next_cur;

    // ==========================================
    // Next state
    always_comb begin
        next_cur        = cur;
        next_cur.strobe = 1'b0;
        if (cur.timer != 8'h00) begin
            next_cur.timer = cur.timer - 8'h01;
        end else if (cur.left == 4'h0) begin
            if (load_in) begin
                next_cur.shift = byte_in;
                next_cur.left  = 4'h8;
                next_cur.timer = 8'h00;
            end
        end else begin
            next_cur.bit_val = cur.shift[0];
            next_cur.strobe  = 1'b1;
            next_cur.shift   = {1'b0, cur.shift[7:1]};
            next_cur.left    = cur.left - 4'h1;
            next_cur.timer   = 8'(BIT_CYCLES - 1);
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign busy_out       = (cur.left != 4'h0) || (cur.timer != 8'h00);
    assign bit_out        = cur.bit_val;
    assign bit_strobe_out = cur.strobe;

endmodule

// file: bench/host_link_model.sv
`timescale 1ns/1ns

module host_link_model (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        reset_in,
    // Device link side
    input  wire logic        tx_bit_in,
    input  wire logic        tx_strobe_in,
    // Host control side
    output logic             turnaround_out,
    output logic [15:0]      rx_errors_out
);
    logic [7:0] byte_q[$];
    logic [7:0] shift = 8'h00;
    int         nbits = 0;

    initial begin
        turnaround_out = 1'b0;
        rx_errors_out  = 16'hFFFF;
    end

    // ==========================================
    // Byte capture
    // bits arrive LSB first
    always @(posedge clk_in) begin
        if (tx_strobe_in && !reset_in) begin
            shift = {tx_bit_in, shift[7:1]};
            nbits = nbits + 1;
            if (nbits == 8) begin
                byte_q.push_back(shift);
                nbits = 0;
            end
        end
    end

    // ==========================================
    // Bus turnaround, only from stop state
    // host hands bus over
    task automatic bus_turn(input logic [15:0] errs);
        @(negedge clk_in);
        turnaround_out = 1'b1;
        rx_errors_out  = errs;
        @(negedge clk_in);
        turnaround_out = 1'b0;
        rx_errors_out  = ~errs;
    endtask
endmodule

// file: bench/framer_assertions.sv
`timescale 1ns/1ns

module framer_assertions
    import resp_framer_pkg::*;
#(
    parameter int MAX_LEN = 16
) (
    // Inputs of the framer
    input  wire logic                    clk_in,
    input  wire logic                    reset_in,
    input  wire logic                    reply_start_in,
    input  wire logic                    reply_generic_in,
    input  wire logic [15:0]             reply_len_in,
    input  wire logic [MAX_LEN-1:0][7:0] reply_data_in,
    input  wire logic                    turnaround_in,
    input  wire logic [15:0]             rx_errors_in,
    // Outputs of the framer
    input  wire logic                    tx_bit_out,
    input  wire logic                    tx_strobe_out,
    input  wire logic                    tx_active_out,
    input  wire logic                    ack_out,
    input  wire logic                    turn_back_out,
    input  wire logic                    rx_discard_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    logic [15:0] bits;
    always_ff @(posedge clk_in) begin
        if (reset_in || !tx_active_out) begin
            bits <= 16'h0000;
        end else if (tx_strobe_out) begin
            bits <= bits + 16'h0001;
        end
    end

    // ==========================================
    // Link timing and framing
    strobe_spacing_a: assert property (tx_strobe_out |=> !tx_strobe_out [*7])
        else $error("strobes closer than eight cycles");
    strobe_in_frame_a: assert property (tx_strobe_out |-> tx_active_out)
        else $error("strobe outside frame");
    first_strobe_a: assert property ($rose(tx_active_out) |-> ##[0:4] tx_strobe_out)
        else $error("first bit late");
    whole_bytes_a: assert property ($fell(tx_active_out) |-> bits[2:0] == 3'h0)
        else $error("frame not whole bytes");
    // ==========================================
    // Turnaround answers and quiet outputs after reset
    ack_after_turn_a: assert property ((turnaround_in && rx_errors_in == 16'h0000 && !tx_active_out)
        ##1 !reply_start_in |=> ack_out)
        else $error("ack missing after clean turnaround");
    turn_after_ack_a: assert property (ack_out |=> turn_back_out && !ack_out)
        else $error("bus not handed back after ack");
    ack_quiet_a: assert property (ack_out |-> !tx_active_out && !rx_discard_out)
        else $error("ack during frame");
    reset_quiet_a: assert property ($fell(reset_in) |-> !tx_active_out && !ack_out
        && !turn_back_out && !rx_discard_out && !tx_strobe_out)
        else $error("outputs active after reset");

    cover property (ack_out);
    cover property (rx_discard_out);
    cover property ($fell(tx_active_out));
    cover property (turn_back_out);
endmodule

bind dsi_read_response_framer framer_assertions #(.MAX_LEN(MAX_LEN)) u_framer_assertions (
    .clk_in(clk_in), .reset_in(reset_in), .reply_start_in(reply_start_in),
    .reply_generic_in(reply_generic_in), .reply_len_in(reply_len_in), .reply_data_in(reply_data_in),
    .turnaround_in(turnaround_in), .rx_errors_in(rx_errors_in), .tx_bit_out(tx_bit_out),
    .tx_strobe_out(tx_strobe_out), .tx_active_out(tx_active_out), .ack_out(ack_out),
    .turn_back_out(turn_back_out), .rx_discard_out(rx_discard_out));

// file: bench/dsi_read_response_framer_tb.sv
`timescale 1ns/1ns
`include "resp_framer_defs.svh"

module dsi_read_response_framer_tb;
    import resp_framer_pkg::*;
    localparam int MAX_LEN = 8;

    logic                    clk_in = 1'b0;
    logic                    reset_in = 1'b1;
    logic                    reply_start_in = 1'b0;
    logic                    reply_generic_in = 1'b0;
    logic [15:0]             reply_len_in = 16'h0000;
    logic [MAX_LEN-1:0][7:0] reply_data_in;
    logic                    turnaround_in;
    logic [15:0]             rx_errors_in;
    logic                    tx_bit, tx_strobe, tx_active, ack, turn_back, discard;
    logic [7:0]              exp_q[$];
    int                      fails = 0, checks = 0, cycles = 0, acks, turns, discards;

    always #25 clk_in = ~clk_in;

    dsi_read_response_framer #(.MAX_LEN(MAX_LEN)) u_dsi_read_response_framer (
        .clk_in(clk_in), .reset_in(reset_in), .reply_start_in(reply_start_in),
        .reply_generic_in(reply_generic_in), .reply_len_in(reply_len_in), .reply_data_in(reply_data_in),
        .turnaround_in(turnaround_in), .rx_errors_in(rx_errors_in), .tx_bit_out(tx_bit),
        .tx_strobe_out(tx_strobe), .tx_active_out(tx_active), .ack_out(ack),
        .turn_back_out(turn_back), .rx_discard_out(discard));

    host_link_model u_host_link_model (
        .clk_in(clk_in), .reset_in(reset_in), .tx_bit_in(tx_bit), .tx_strobe_in(tx_strobe),
        .turnaround_out(turnaround_in), .rx_errors_out(rx_errors_in));

    always @(posedge clk_in) begin
        cycles++;
        acks += ack;
        turns += turn_back;
        discards += discard;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end

    // ==========================================
    // Compare and expectation helpers
    task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_frames();
        check_val("byte count", 16'(exp_q.size()), 16'(u_host_link_model.byte_q.size()));
        foreach (exp_q[i]) check_val("byte", {8'h00, exp_q[i]}, {8'h00, u_host_link_model.byte_q[i]});
    endtask

    function automatic logic [7:0] ecc_of(input logic [23:0] h);
        logic [23:0] m[6] = '{24'hF12CB7, 24'hF2555B, 24'h749A6D, 24'hB8E38E, 24'hDF03F0, 24'hEFFC00};
        logic [7:0]  e = 8'h00;
        for (int i = 0; i < 6; i++) e[i] = ^(h & m[i]);
        return e;
    endfunction

    task automatic push_hdr(input logic [23:0] h);
        exp_q.push_back(h[7:0]);
        exp_q.push_back(h[15:8]);
        exp_q.push_back(h[23:16]);
        exp_q.push_back(ecc_of(h));
    endtask

    task automatic push_long(input logic [5:0] dt, input logic [15:0] len);
        logic [15:0] crc = `CRC_SEED;
        push_hdr({len, 2'b00, dt});
        for (int i = 0; i < len; i++) begin
            exp_q.push_back(reply_data_in[i]);
            for (int b = 0; b < 8; b++) crc = (crc[0] ^ reply_data_in[i][b]) ? ((crc >> 1) ^ 16'h8408) : (crc >> 1);
        end
        exp_q.push_back(crc[7:0]);
        exp_q.push_back(crc[15:8]);
    endtask

    task automatic run_seq(input logic gen, input logic [15:0] len, input logic [15:0] errs, input logic go);
        int n = 0;
        u_host_link_model.byte_q.delete();
        u_host_link_model.nbits = 0;
        acks = 0;
        turns = 0;
        discards = 0;
        reply_generic_in = gen;
        reply_len_in = len;
        u_host_link_model.bus_turn(errs);
        reply_start_in = go;
        @(negedge clk_in);
        reply_start_in = 1'b0;
        while (turns == 0 && n < 3000) begin
            @(negedge clk_in);
            n++;
        end
        repeat (4) @(negedge clk_in);
        check_val("turn back", 16'h0001, 16'(turns));
    endtask

    // ==========================================
    // Scenarios
    task automatic test_short();
        logic [5:0] dt[2][2] = '{'{6'h21, 6'h22}, '{6'h11, 6'h12}};
        for (int g = 0; g < 2; g++) for (int l = 1; l < 3; l++) begin
            exp_q.delete();
            push_hdr({(l == 1) ? 8'h00 : reply_data_in[1], reply_data_in[0], 2'b00, dt[g][l-1]});
            run_seq(g[0], 16'(l), 16'h0000, 1'b1);
            check_frames();
        end
    endtask

    task automatic test_long();
        for (int g = 0; g < 2; g++) for (int l = 5; l <= MAX_LEN; l += 3) begin
            exp_q.delete();
            push_long(g ? 6'h1A : 6'h1C, 16'(l));
            run_seq(g[0], 16'(l), 16'h0000, 1'b1);
            check_frames();
        end
    endtask

    task automatic test_ack();
        exp_q.delete();
        run_seq(1'b0, 16'h0001, 16'h0000, 1'b0);
        check_frames();
        check_val("ack pulses", 16'h0001, 16'(acks));
    endtask

    task automatic test_error();
        exp_q.delete();
        push_hdr({8'h04, 8'h00, 8'h02});
        run_seq(1'b1, 16'h0002, 16'h0400, 1'b0);
        check_frames();
        check_val("discards", 16'h0001, 16'(discards));
        check_val("ack pulses", 16'h0000, 16'(acks));
    endtask

    task automatic test_corrected();
        exp_q.delete();
        push_hdr({reply_data_in[1], reply_data_in[0], 8'h22});
        push_hdr({8'h01, 8'h00, 8'h02});
        run_seq(1'b0, 16'h0002, 16'h0100, 1'b1);
        check_frames();
    endtask

    task automatic finish_test();
        if (fails == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        reply_data_in = {8'hFF, 8'h00, 8'h5A, 8'hE2, 8'hA2, 8'h12, 8'h23, 8'h89};
        repeat (20) @(negedge clk_in);
        reset_in = 1'b0;
        check_val("idle active", 16'h0000, {15'h0000, tx_active});
        test_short();
        test_long();
        test_ack();
        test_error();
        test_corrected();
        finish_test();
    end
endmodule
